// ---- verilog/supervisor_pkg.sv ----
// Constants, types and timing counts for the supervisory sequencer.
// Assumes a 10 MHz core clock and comparator flags already synchronous.
package supervisor_pkg;
  localparam int rail_count = 6;
  localparam int clock_khz = 10000;
  localparam int switch_khz = 3000;
  localparam int blank_us = 50;
  localparam int step_us = 128;
  localparam int blank_cycles = blank_us * clock_khz / 1000;
  localparam int step_cycles = step_us * clock_khz / 1000;
  localparam int pg_ticks = 16;
  localparam logic [5:0] rail_enable_reset = 6'h00;
  localparam logic [5:0] discharge_reset = 6'h3f;
  localparam logic [2:0] start_delay_reset = 3'h0;
  localparam logic [1:0] restart_defaults = 2'h0;
  typedef struct packed {
    logic undervoltage;
    logic thermal_warning;
    logic thermal_shutdown;
    logic thermal_thermal_restart_select;
  } flags_t;
  typedef struct packed {
    logic [5:0] rail_enable;
    logic [5:0] discharge_control_register;
    logic [2:0] sequence_start_delay;
    logic [1:0] thermal_restart_select;
  } config_t;
endpackage

// ---- verilog/tick_divider.sv ----
// Fractional divider producing one-cycle enable pulses at an average rate.
// Assumes the reset input clears it together with the rest of the block.
module tick_divider #(
  parameter int num = 3,
  parameter int den = 10
) (
  input wire logic clock,
  input wire logic reset,
  output logic tick
);
  logic [7:0] acc_reg;
  logic [8:0] sum;
  assign sum = {1'b0, acc_reg} + 9'(num);
  assign tick = sum >= 9'(den);
  always_ff @(posedge clock)
  begin
    if (reset)
      acc_reg <= 8'h00;
    else
      acc_reg <= tick ? 8'(sum - 9'(den)) : sum[7:0];
  end
endmodule

// ---- verilog/pmic_supervisor_sequencer.sv ----
// Supervisory state machine: lockout, thermal, discharge, sequencing, power-good.
// Assumes comparator flags and pins are synchronous to the 10 MHz clock.
module pmic_supervisor_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire logic hw_enable_pin,
  input wire supervisor_pkg::flags_t flags,
  input wire supervisor_pkg::config_t host_config,
  input wire logic config_write,
  input wire logic status_read,
  output logic [5:0] rail_on,
  output logic [5:0] discharge_on,
  output logic rails_high_z,
  output logic switch_tick,
  output logic bus_nack,
  output logic power_good_sense,
  output logic power_good_event,
  output logic thermal_warning_event,
  output logic thermal_shutdown_active,
  output supervisor_pkg::config_t active_config
);
  typedef enum logic [2:0] {st_off, st_delay, st_up, st_on, st_down, st_thermal} state_t;
  state_t state_reg;
  state_t state_next;
  logic [13:0] count_reg;
  logic [2:0] index_reg;
  logic [5:0] seq_mask_reg;
  logic [4:0] pg_count_reg;
  logic [9:0] blank_reg;
  logic hw_enable_last_reg;
  logic warn_last_reg;
  logic down_discharge_reg;
  supervisor_pkg::config_t cfg_reg;
  logic in_lockout;
  logic en_rise;
  logic en_fall;
  logic core_active;
  logic thermal_trip;
  logic count_done;
  // Wide enough for the longest start delay, seven full steps
  logic [13:0] delay_cycles;

  // Lockout acts as a reset on everything below
  assign in_lockout = reset || flags.undervoltage;
  // A pull-down outside makes a floating pin read low; no latch of a high level
  assign en_rise = hw_enable_pin && !hw_enable_last_reg;
  assign en_fall = !hw_enable_pin && hw_enable_last_reg;
  assign core_active = |rail_on;
  assign thermal_trip = core_active && flags.thermal_shutdown;
  assign delay_cycles = 14'(supervisor_pkg::step_cycles) * 14'(cfg_reg.sequence_start_delay);
  assign count_done = count_reg == 14'h0000;

  tick_divider #(
    .num(supervisor_pkg::switch_khz / 100),
    .den(supervisor_pkg::clock_khz / 100)
  ) u_switch_clock (
    .clock(clock),
    .reset(in_lockout),
    .tick(switch_tick)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_off:
        if (en_rise)
          state_next = st_delay;
      st_delay:
        if (!hw_enable_pin)
          state_next = st_off;
        else if (count_done)
          state_next = st_up;
      st_up:
        if (!hw_enable_pin)
          state_next = st_down;
        else if (count_done && index_reg == 3'(supervisor_pkg::rail_count - 1))
          state_next = st_on;
      st_on:
        if (en_fall)
          state_next = st_down;
      st_down:
        if (count_done && index_reg == 3'h0)
          state_next = st_off;
      st_thermal:
        if (flags.thermal_thermal_restart_select)
          state_next = st_off;
    endcase
    if (thermal_trip)
      state_next = st_thermal;
  end

  always_ff @(posedge clock)
  begin
    if (in_lockout)
    begin
      state_reg <= st_off;
      count_reg <= 14'h0000;
      index_reg <= 3'h0;
      seq_mask_reg <= 6'h00;
      hw_enable_last_reg <= 1'b0;
      warn_last_reg <= 1'b0;
      down_discharge_reg <= 1'b1;
      cfg_reg <= {supervisor_pkg::rail_enable_reset, supervisor_pkg::discharge_reset,
        supervisor_pkg::start_delay_reset, supervisor_pkg::restart_defaults};
    end
    else
    begin
      state_reg <= state_next;
      hw_enable_last_reg <= hw_enable_pin;
      warn_last_reg <= flags.thermal_warning;
      if (config_write && !bus_nack)
        cfg_reg <= host_config;
      else if (state_reg == st_thermal && state_next == st_off
        && cfg_reg.thermal_restart_select == supervisor_pkg::restart_defaults)
        cfg_reg <= {supervisor_pkg::rail_enable_reset, supervisor_pkg::discharge_reset,
          supervisor_pkg::start_delay_reset, supervisor_pkg::restart_defaults};
      if (state_next == st_on)
        down_discharge_reg <= 1'b0;
      else if (state_next != state_reg)
        down_discharge_reg <= 1'b1;
      if (state_next == st_delay && state_reg == st_off)
        count_reg <= delay_cycles;
      else if ((state_next == st_up && state_reg == st_delay) || (!count_done))
        count_reg <= count_done ? 14'(supervisor_pkg::step_cycles) : count_reg - 14'h0001;
      else if (state_reg == st_up || state_reg == st_down)
        count_reg <= 14'(supervisor_pkg::step_cycles);
      if (state_next == st_thermal)
        seq_mask_reg <= 6'h00;
      else if (state_reg == st_up && count_done)
      begin
        seq_mask_reg[index_reg] <= 1'b1;
        if (state_next == st_up)
          index_reg <= index_reg + 3'h1;
      end
      else if (state_reg == st_down && count_done)
      begin
        seq_mask_reg[index_reg] <= 1'b0;
        if (index_reg != 3'h0)
          index_reg <= index_reg - 3'h1;
      end
      else if (state_reg == st_off)
        index_reg <= 3'h0;
    end
  end

  // Power-good counter, blanking timer and events
  always_ff @(posedge clock)
  begin
    if (in_lockout)
    begin
      pg_count_reg <= 5'h00;
      power_good_sense <= 1'b0;
      power_good_event <= 1'b0;
      thermal_warning_event <= 1'b0;
      blank_reg <= 10'(supervisor_pkg::blank_cycles);
    end
    else
    begin
      if (blank_reg != 10'h000)
        blank_reg <= blank_reg - 10'h001;
      if (state_reg != st_on)
      begin
        pg_count_reg <= 5'h00;
        power_good_sense <= 1'b0;
      end
      else if (pg_count_reg != 5'(supervisor_pkg::pg_ticks))
        pg_count_reg <= pg_count_reg + 5'h01;
      else
        power_good_sense <= 1'b1;
      // Set wins over a clear arriving in the same cycle
      if (state_reg == st_on && pg_count_reg == 5'(supervisor_pkg::pg_ticks) && !power_good_sense)
        power_good_event <= 1'b1;
      else if (status_read || !hw_enable_pin)
        power_good_event <= 1'b0;
      if (flags.thermal_warning && !warn_last_reg)
        thermal_warning_event <= 1'b1;
      else if (status_read)
        thermal_warning_event <= 1'b0;
    end
  end

  assign bus_nack = in_lockout || blank_reg != 10'h000;
  assign thermal_shutdown_active = state_reg == st_thermal;
  assign rail_on = (in_lockout || state_reg == st_thermal) ? 6'h00
    : (state_reg == st_on ? cfg_reg.rail_enable : seq_mask_reg & cfg_reg.rail_enable);
  assign rails_high_z = in_lockout;
  assign discharge_on = in_lockout ? 6'h00
    : (down_discharge_reg ? 6'h3f : cfg_reg.discharge_control_register) & ~rail_on;
  assign active_config = cfg_reg;

  a_thermal_forces_off: assert property (@(posedge clock) disable iff (reset)
    state_reg == st_thermal |-> rail_on == 6'h00) else $error("rail on in shutdown");
  a_lockout_rails_off: assert property (@(posedge clock)
    flags.undervoltage |-> rail_on == 6'h00 && rails_high_z) else $error("rail on in lockout");
  a_rise_starts_seq: assert property (@(posedge clock) disable iff (in_lockout)
    state_reg == st_off && en_rise && !thermal_trip |=> state_reg == st_delay)
    else $error("enable rise ignored");
  a_nack_blanking: assert property (@(posedge clock) disable iff (in_lockout)
    $fell(reset) |-> bus_nack [*8]) else $error("bus open during blanking");
  a_thermal_restart_select_exit: assert property (@(posedge clock) disable iff (in_lockout)
    state_reg == st_thermal && !flags.thermal_thermal_restart_select && !thermal_trip |=> state_reg == st_thermal)
    else $error("left shutdown without thermal_restart_select");
  a_pg_low_early: assert property (@(posedge clock) disable iff (in_lockout)
    $rose(state_reg == st_on) |-> !power_good_sense [*8]) else $error("power good early");
  a_warn_event: assert property (@(posedge clock) disable iff (in_lockout)
    $rose(flags.thermal_warning) |=> thermal_warning_event) else $error("warning lost");
  a_discharge_off: assert property (@(posedge clock) disable iff (in_lockout)
    state_reg == st_off |-> discharge_on == 6'h3f) else $error("no discharge when off");
  // A shutdown flag with every rail off must never trip protection
  a_arm_only_active: assert property (@(posedge clock) disable iff (in_lockout)
    state_reg != st_thermal && !core_active |=> state_reg != st_thermal)
    else $error("thermal armed while idle");
endmodule

// ---- dv/host_model.sv ----
// Host side: register writes and status reads toward the sequencer.
// Assumes the bench calls its tasks; strobes move on the falling edge.
module host_model (
  input wire logic clock,
  output supervisor_pkg::config_t host_config,
  output logic config_write,
  output logic status_read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    host_config = 17'h00000;
    config_write = 1'b0;
    status_read = 1'b0;
  end
  // Data is inverted once the strobe drops so a stale value never looks valid
  task automatic write_config(input supervisor_pkg::config_t value);
    @(negedge clock);
    host_config <= value;
    config_write <= 1'b1;
    @(negedge clock);
    config_write <= 1'b0;
    host_config <= ~value;
  endtask
  task automatic read_status();
    @(negedge clock);
    status_read <= 1'b1;
    @(negedge clock);
    status_read <= 1'b0;
  endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the supervisory sequencer.
// Assumes a 10 MHz clock and comparator flags driven on the falling edge.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hw_enable_pin = 1'b0;
  supervisor_pkg::flags_t flags = 4'h0;
  supervisor_pkg::config_t host_config, active_config, cfg;
  logic config_write, status_read, rails_high_z, switch_tick, bus_nack;
  logic power_good_sense, power_good_event, thermal_warning_event, thermal_shutdown_active;
  logic [5:0] rail_on, discharge_on;
  int num_errors = 0;
  int comparisons = 0;
  int ticks;
  localparam supervisor_pkg::config_t defaults = {supervisor_pkg::rail_enable_reset,
    supervisor_pkg::discharge_reset, supervisor_pkg::start_delay_reset,
    supervisor_pkg::restart_defaults};
  always #50 clock = ~clock;
  pmic_supervisor_sequencer u_pmic_supervisor_sequencer (.clock, .reset, .hw_enable_pin,
    .flags, .host_config, .config_write, .status_read, .rail_on, .discharge_on,
    .rails_high_z, .switch_tick, .bus_nack, .power_good_sense, .power_good_event,
    .thermal_warning_event, .thermal_shutdown_active, .active_config);
  host_model u_host_model (.clock, .host_config, .config_write, .status_read);
  task automatic check(input logic [16:0] seen, input logic [16:0] expected);
    comparisons++;
    if (seen !== expected)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Waits for power-good, or for the rails to leave a given pattern
  task automatic wait_for(input logic pg, input logic [5:0] from);
    int n;
    n = 0;
    while ((pg ? power_good_sense !== 1'b1 : rail_on === from) && n < 20000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 20000)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  initial
  begin
    repeat (16) @(negedge clock);
    check(rail_on, 6'h00);
    check(rails_high_z, 1'b1);
    check(bus_nack, 1'b1);
    reset <= 1'b0;
    repeat (2) @(negedge clock);
    check(discharge_on, 6'h3f);
    cfg = {6'h0f, 6'h2a, 3'h1, 2'h1};
    u_host_model.write_config(cfg);
    @(negedge clock);
    check(active_config, defaults);
    repeat (500) @(negedge clock);
    check(bus_nack, 1'b0);
    u_host_model.write_config(cfg);
    @(negedge clock);
    check(active_config, cfg);
    flags.thermal_shutdown <= 1'b1;
    repeat (3) @(negedge clock);
    check(thermal_shutdown_active, 1'b0);
    flags.thermal_shutdown <= 1'b0;
    ticks = 0;
    repeat (100)
    begin
      @(negedge clock);
      ticks += int'(switch_tick === 1'b1);
    end
    check(17'(ticks), 17'h0001e);
    // Restart select 01 keeps settings, then 00 reloads defaults
    for (int i = 0; i < 2; i++)
    begin
      cfg.thermal_restart_select = 2'(1 - i);
      u_host_model.write_config(cfg);
      hw_enable_pin <= 1'b1;
      wait_for(1'b0, 6'h00);
      check(rail_on, 6'h01);
      check(power_good_sense, 1'b0);
      wait_for(1'b1, 6'h00);
      check(rail_on, 6'h0f);
      check(discharge_on, 6'h20);
      check(power_good_event, 1'b1);
      flags.thermal_warning <= 1'b1;
      repeat (2) @(negedge clock);
      check(thermal_warning_event, 1'b1);
      u_host_model.read_status();
      check({power_good_event, thermal_warning_event}, 2'h0);
      flags <= 4'h2;
      repeat (2) @(negedge clock);
      check(rail_on, 6'h00);
      check(discharge_on, 6'h3f);
      flags <= 4'h0;
      repeat (3) @(negedge clock);
      check(thermal_shutdown_active, 1'b1);
      flags.thermal_thermal_restart_select <= 1'b1;
      repeat (2) @(negedge clock);
      flags.thermal_thermal_restart_select <= 1'b0;
      check(thermal_shutdown_active, 1'b0);
      check(active_config, i ? defaults : cfg);
      hw_enable_pin <= 1'b0;
      @(negedge clock);
    end
    // Longest start delay: no rail may come up before seven steps
    cfg.sequence_start_delay = 3'h7;
    u_host_model.write_config(cfg);
    hw_enable_pin <= 1'b1;
    repeat (8900) @(negedge clock);
    check(rail_on, 6'h00);
    check(discharge_on, 6'h3f);
    wait_for(1'b1, 6'h00);
    hw_enable_pin <= 1'b0;
    wait_for(1'b0, 6'h0f);
    check(rail_on, 6'h07);
    check(power_good_event, 1'b0);
    flags.undervoltage <= 1'b1;
    repeat (2) @(negedge clock);
    check(rail_on, 6'h00);
    check(rails_high_z, 1'b1);
    stop_test();
  end
endmodule
